// ### pkg/rot_cfg.svh
// offsets, fields, reset values and opcodes of the byte rotate unit
//
// Functional notes
// RQ1: plain left rotate moves bit n to n+1, bit 7 to 0; carry untouched.
// RQ2: right rotate via carry: bit n to n-1, bit 0 to carry, carry to 7.
// RQ3: plain right rotate moves bit n to n-1, bit 0 to bit 7; N, Z only.
// RQ4: plain right rotate neither reads nor alters carry; uses operand only.
// RQ5: destination bit 0 writes result to accumulator, file register unchanged.
// RQ6: destination bit 1 writes result back into the addressed file register.
// RQ7: access bit 0 addresses the access bank, ignoring the bank select register.
// RQ8: access bit 1 takes the operand bank from the bank select register.
// RQ9: file address field is eight bits; destination and access one bit each.
// RQ10: opcodes 0100 01, 0011 00, 0100 00 select the three rotates.
// RQ11: each rotate is one word, one cycle of four phases.
// RQ12: negative equals result bit 7; zero set exactly when result is zero.
`ifndef ROT_CFG_SVH
`define ROT_CFG_SVH

// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define OFF_INSTR 12'h000
`define OFF_STATUS 12'h004
`define OFF_WREG 12'h008
`define OFF_BANK 12'h00c
`define OFF_MADDR 12'h010
`define OFF_MDATA 12'h014

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_C 0
`define ST_Z 2
`define ST_N 4
`define ST_BUSY 8
`define ST_BAD 9

// ----------------------------------------
// instruction fields and opcodes
// ----------------------------------------
`define IN_DST 9
`define IN_ACC 8
`define OPC_RL_PLAIN 6'h11
`define OPC_RR_CARRY 6'h0c
`define OPC_RR_PLAIN 6'h10

// ----------------------------------------
// memory geometry and reset values
// ----------------------------------------
`define BANK_W 4
`define DATA_AW 12
`define MEM_DEPTH 4096
`define ACC_SPLIT 8'h80
`define RST_WREG 8'h00
`define RST_BANK 4'h0

`endif

// ### pkg/rot_pkg.sv
// types shared by the byte rotate unit and its rotator
`include "rot_cfg.svh"
`default_nettype none
package rot_pkg;

   typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_t;

   typedef enum logic [1:0] {OP_NONE, OP_RL_PLAIN, OP_RR_CARRY, OP_RR_PLAIN} op_t;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic n;
      logic z;
   } alu_out_t;

   typedef struct packed {
      phase_t phase;
      op_t op;
      logic [15:0] instr;
      logic dst;
      logic acc;
      logic [`DATA_AW-1:0] addr;
      logic [7:0] opnd;
      alu_out_t alu;
      logic c;
      logic n;
      logic z;
      logic bad;
      logic [7:0] wreg;
      logic [`BANK_W-1:0] bank;
      logic [`DATA_AW-1:0] maddr;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;

endpackage
`default_nettype wire

// ### verilog/rotate_alu.sv
// combinational byte rotator with flag generation
`include "rot_cfg.svh"
`default_nettype none
module rotate_alu (
   // operation
   input wire rot_pkg::op_t op,
   input wire logic [7:0] opnd,
   input wire logic carry_in,
   // result
   output rot_pkg::alu_out_t result
);

   always_comb begin
      result.res = opnd;
      result.c = carry_in;
      case (op)
         // RQ1 rotate left plain
         rot_pkg::OP_RL_PLAIN: begin
            result.res = {opnd[6:0], opnd[7]};
         end
         // RQ2 carry into bit 7
         rot_pkg::OP_RR_CARRY: begin
            result.res = {carry_in, opnd[7:1]};
            result.c = opnd[0];
         end
         // RQ3 RQ4 carry not used
         rot_pkg::OP_RR_PLAIN: begin
            result.res = {opnd[0], opnd[7:1]};
         end
         default: begin
         end
      endcase
      // RQ12 flags from result
      result.n = result.res[7];
      result.z = (result.res == 8'h00);
   end

endmodule
`default_nettype wire

// ### verilog/byte_rotate_unit.sv
// byte rotate datapath with file memory, reached over apb
//
// Register access over APB and the address map are this design's own decisions.
`include "rot_cfg.svh"
`default_nettype none
module byte_rotate_unit (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // core state
   output logic [7:0] WREG_OUT,
   output logic [2:0] FLAGS_OUT,
   output logic BUSY
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [`DATA_AW-1:0] map_addr(input logic acc,
         input logic [`BANK_W-1:0] bank, input logic [7:0] f);
      if (acc) begin
         map_addr = {bank, f};
      end else if (f < `ACC_SPLIT) begin
         map_addr = {{`BANK_W{1'b0}}, f};
      end else begin
         map_addr = {{`BANK_W{1'b1}}, f};
      end
   endfunction

   function automatic rot_pkg::op_t decode_op(input logic [15:0] ins);
      if (ins[15:10] == `OPC_RL_PLAIN) begin
         decode_op = rot_pkg::OP_RL_PLAIN;
      end else if (ins[15:10] == `OPC_RR_CARRY) begin
         decode_op = rot_pkg::OP_RR_CARRY;
      end else if (ins[15:10] == `OPC_RR_PLAIN) begin
         decode_op = rot_pkg::OP_RR_PLAIN;
      end else begin
         decode_op = rot_pkg::OP_NONE;
      end
   endfunction

   // ----------------------------------------
   // state, memory and rotator
   // ----------------------------------------
   rot_pkg::state_t s_r;
   rot_pkg::state_t s_nxt;
   rot_pkg::alu_out_t alu_q;
   logic [7:0] mem [0:`MEM_DEPTH-1];
   logic [7:0] op_rd;
   logic [7:0] sw_rd;
   logic mem_we;
   logic [`DATA_AW-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic busy;
   logic apb_setup;
   logic apb_acc;
   logic wr_ok;

   assign busy = (s_r.phase != rot_pkg::PH_IDLE);
   assign apb_setup = PSEL && !PENABLE;
   assign apb_acc = PSEL && PENABLE;
   // error latched at setup also blocks the write
   assign wr_ok = apb_acc && PWRITE && !s_r.pslverr;
   assign op_rd = mem[s_r.addr];
   assign sw_rd = mem[s_r.maddr];

   rotate_alu u_alu (
      .op(s_r.op),
      .opnd(s_r.opnd),
      .carry_in(s_r.c),
      .result(alu_q)
   );

   // ----------------------------------------
   // file memory write port
   // ----------------------------------------
   always_comb begin
      mem_we = 1'b0;
      mem_wa = s_r.maddr;
      mem_wd = PWDATA[7:0];
      // RQ6 result back to file
      if (s_r.phase == rot_pkg::PH_WRITE && s_r.dst) begin
         mem_we = 1'b1;
         mem_wa = s_r.addr;
         mem_wd = s_r.alu.res;
      end else if (wr_ok && PADDR == `OFF_MDATA) begin
         mem_we = 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (apb_setup) begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata = 32'h0000_0000;
         if (PADDR == `OFF_INSTR) begin
            s_nxt.prdata[15:0] = s_r.instr;
         end else if (PADDR == `OFF_STATUS) begin
            s_nxt.prdata[`ST_C] = s_r.c;
            s_nxt.prdata[`ST_Z] = s_r.z;
            s_nxt.prdata[`ST_N] = s_r.n;
            s_nxt.prdata[`ST_BUSY] = busy;
            s_nxt.prdata[`ST_BAD] = s_r.bad;
         end else if (PADDR == `OFF_WREG) begin
            s_nxt.prdata[7:0] = s_r.wreg;
         end else if (PADDR == `OFF_BANK) begin
            s_nxt.prdata[`BANK_W-1:0] = s_r.bank;
         end else if (PADDR == `OFF_MADDR) begin
            s_nxt.prdata[`DATA_AW-1:0] = s_r.maddr;
         end else if (PADDR == `OFF_MDATA) begin
            s_nxt.prdata[7:0] = sw_rd;
         end else begin
            s_nxt.pslverr = 1'b1;
         end
         // a running instruction owns every register
         if (PWRITE && busy) begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (wr_ok) begin
         if (PADDR == `OFF_INSTR) begin
            s_nxt.instr = PWDATA[15:0];
            s_nxt.phase = rot_pkg::PH_DECODE;
         end else if (PADDR == `OFF_STATUS) begin
            s_nxt.c = PWDATA[`ST_C];
            s_nxt.z = PWDATA[`ST_Z];
            s_nxt.n = PWDATA[`ST_N];
         end else if (PADDR == `OFF_WREG) begin
            s_nxt.wreg = PWDATA[7:0];
         end else if (PADDR == `OFF_BANK) begin
            s_nxt.bank = PWDATA[`BANK_W-1:0];
         end else if (PADDR == `OFF_MADDR) begin
            s_nxt.maddr = PWDATA[`DATA_AW-1:0];
         end
      end
      case (s_r.phase)
         // RQ10 opcode decode
         rot_pkg::PH_DECODE: begin
            s_nxt.op = decode_op(s_r.instr);
            // RQ9 eight bit file field
            s_nxt.dst = s_r.instr[`IN_DST];
            s_nxt.acc = s_r.instr[`IN_ACC];
            // RQ7 RQ8 bank choice
            s_nxt.addr = map_addr(s_r.instr[`IN_ACC], s_r.bank, s_r.instr[7:0]);
            if (decode_op(s_r.instr) == rot_pkg::OP_NONE) begin
               s_nxt.bad = 1'b1;
               s_nxt.phase = rot_pkg::PH_IDLE;
            end else begin
               s_nxt.bad = 1'b0;
               s_nxt.phase = rot_pkg::PH_READ;
            end
         end
         // RQ11 read operand phase
         rot_pkg::PH_READ: begin
            s_nxt.opnd = op_rd;
            s_nxt.phase = rot_pkg::PH_PROC;
         end
         rot_pkg::PH_PROC: begin
            s_nxt.alu = alu_q;
            s_nxt.phase = rot_pkg::PH_WRITE;
         end
         rot_pkg::PH_WRITE: begin
            // RQ5 result to accumulator
            if (!s_r.dst) begin
               s_nxt.wreg = s_r.alu.res;
            end
            // RQ2 only this one moves carry
            if (s_r.op == rot_pkg::OP_RR_CARRY) begin
               s_nxt.c = s_r.alu.c;
            end
            // RQ12 negative and zero
            s_nxt.n = s_r.alu.n;
            s_nxt.z = s_r.alu.z;
            s_nxt.phase = rot_pkg::PH_IDLE;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
         s_r.phase <= rot_pkg::PH_IDLE;
         s_r.op <= rot_pkg::OP_NONE;
         s_r.wreg <= `RST_WREG;
         s_r.bank <= `RST_BANK;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign PRDATA = s_r.prdata;
   assign PREADY = apb_acc;
   assign PSLVERR = apb_acc && s_r.pslverr;
   assign WREG_OUT = s_r.wreg;
   assign FLAGS_OUT = {s_r.n, s_r.z, s_r.c};
   assign BUSY = busy;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic in_wr;
   assign in_wr = (s_r.phase == rot_pkg::PH_WRITE);

   property p_rl_plain;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr && s_r.op == rot_pkg::OP_RL_PLAIN |->
         s_r.alu.res == {s_r.opnd[6:0], s_r.opnd[7]} ##1 s_r.c == $past(s_r.c);
   endproperty
   a_rl_plain: assert property (p_rl_plain) else $error("plain left rotate wrong"); // RQ1

   property p_rr_carry;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr && s_r.op == rot_pkg::OP_RR_CARRY |->
         s_r.alu.res == {s_r.c, s_r.opnd[7:1]} ##1 s_r.c == $past(s_r.opnd[0]);
   endproperty
   a_rr_carry: assert property (p_rr_carry) else $error("rotate through carry wrong"); // RQ2

   property p_rr_plain;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr && s_r.op == rot_pkg::OP_RR_PLAIN |->
         s_r.alu.res == {s_r.opnd[0], s_r.opnd[7:1]};
   endproperty
   a_rr_plain: assert property (p_rr_plain) else $error("plain right rotate wrong"); // RQ3

   property p_rr_keep_c;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_DECODE && s_r.instr[15:10] == `OPC_RR_PLAIN |->
         ##3 $stable(s_r.c) ##1 $stable(s_r.c);
   endproperty
   a_rr_keep_c: assert property (p_rr_keep_c) else $error("plain right rotate moved carry"); // RQ4

   property p_dst_w;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr && !s_r.dst |-> !mem_we ##1 s_r.wreg == $past(s_r.alu.res);
   endproperty
   a_dst_w: assert property (p_dst_w) else $error("accumulator destination wrong"); // RQ5

   property p_dst_f;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr && s_r.dst |-> mem_we && mem_wa == s_r.addr && mem_wd == s_r.alu.res
         ##1 $stable(s_r.wreg);
   endproperty
   a_dst_f: assert property (p_dst_f) else $error("file destination wrong"); // RQ6

   property p_acc_bank;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_READ && !s_r.acc |->
         s_r.addr[`DATA_AW-1:8] == (s_r.addr[7] ? {`BANK_W{1'b1}} : {`BANK_W{1'b0}});
   endproperty
   a_acc_bank: assert property (p_acc_bank) else $error("access bank address wrong"); // RQ7

   property p_sel_bank;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_READ && s_r.acc |-> s_r.addr[`DATA_AW-1:8] == s_r.bank;
   endproperty
   a_sel_bank: assert property (p_sel_bank) else $error("bank select address wrong"); // RQ8

   property p_field;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_DECODE |=> s_r.addr[7:0] == $past(s_r.instr[7:0])
         && s_r.dst == $past(s_r.instr[`IN_DST]) && s_r.acc == $past(s_r.instr[`IN_ACC]);
   endproperty
   a_field: assert property (p_field) else $error("operand fields wrong"); // RQ9

   property p_decode;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_DECODE && s_r.instr[15:10] == `OPC_RL_PLAIN |=>
         s_r.op == rot_pkg::OP_RL_PLAIN && s_r.phase == rot_pkg::PH_READ;
   endproperty
   a_decode: assert property (p_decode) else $error("left rotate not decoded"); // RQ10

   property p_undef;
      @(posedge CLOCK) disable iff (!RST_N)
      s_r.phase == rot_pkg::PH_DECODE && decode_op(s_r.instr) == rot_pkg::OP_NONE |=>
         s_r.bad && !busy;
   endproperty
   a_undef: assert property (p_undef) else $error("unknown opcode executed"); // RQ10

   sequence s_issue;
      wr_ok && PADDR == `OFF_INSTR && decode_op(PWDATA[15:0]) != rot_pkg::OP_NONE;
   endsequence
   sequence s_four_phases;
      s_r.phase == rot_pkg::PH_DECODE ##1 s_r.phase == rot_pkg::PH_READ
         ##1 s_r.phase == rot_pkg::PH_PROC ##1 s_r.phase == rot_pkg::PH_WRITE
         ##1 s_r.phase == rot_pkg::PH_IDLE;
   endsequence
   property p_cycle;
      @(posedge CLOCK) disable iff (!RST_N)
      s_issue |=> s_four_phases;
   endproperty
   a_cycle: assert property (p_cycle) else $error("instruction phases wrong"); // RQ11

   property p_flags;
      @(posedge CLOCK) disable iff (!RST_N)
      in_wr |=> s_r.n == $past(s_r.alu.res[7]) && s_r.z == ($past(s_r.alu.res) == 8'h00);
   endproperty
   a_flags: assert property (p_flags) else $error("negative or zero flag wrong"); // RQ12

endmodule
`default_nettype wire

// ### verification/byte_rotate_unit_bench.sv
// self-checking bench for the byte rotate unit
`include "rot_cfg.svh"
`default_nettype none
module byte_rotate_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clock;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic [7:0] wreg_out;
   logic [2:0] flags_out;
   int err_total;
   int comparisons;
   logic [31:0] rd;
   logic er;
   logic [31:0] r;
   int cnt;
   logic [5:0] ops [3] = '{`OPC_RL_PLAIN, `OPC_RR_CARRY, `OPC_RR_PLAIN};

   byte_rotate_unit u_byte_rotate_unit (
      .CLOCK(clock), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WREG_OUT(wreg_out), .FLAGS_OUT(flags_out), .BUSY(busy)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one apb transfer; leaves the bus idle for one cycle afterwards
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         $display("[ERR] pready expected 1 seen timeout");
         err_total++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   // busy read as it stood before each edge lands; first read is the decode cycle
   task automatic wait_idle(output int c);
      c = 0;
      while (busy === 1'b1 && c < 32) begin
         @(posedge clock);
         c++;
      end
      if (c >= 32) begin
         $display("[ERR] busy expected 0 seen timeout");
         err_total++;
         end_sim();
      end
   endtask

   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [11:0] eaddr(input logic a, input logic [3:0] b, input logic [7:0] f);
      if (a) return {b, f};
      return (f < 8'h80) ? {4'h0, f} : {4'hf, f};
   endfunction

   // returns {carry out, result}
   function automatic logic [8:0] rot(input logic [5:0] opc, input logic [7:0] v, input logic c);
      case (opc)
         `OPC_RL_PLAIN: return {c, v[6:0], v[7]};
         `OPC_RR_CARRY: return {v[0], c, v[7:1]};
         default: return {c, v[0], v[7:1]};
      endcase
   endfunction

   // decoy at the other bank mapping catches a wrong access select
   task automatic run_op(input logic [5:0] opc, input logic d, input logic a,
                         input logic [3:0] b, input logic [7:0] f, input logic [7:0] v,
                         input logic c);
      logic [11:0] ad;
      logic [8:0] x;
      int n;
      ad = eaddr(a, b, f);
      x = rot(opc, v, c);
      apb(1'b1, `OFF_BANK, {28'h0, b});
      apb(1'b1, `OFF_MADDR, {20'h0, eaddr(!a, b, f)});
      apb(1'b1, `OFF_MDATA, {24'h0, ~v});
      apb(1'b1, `OFF_MADDR, {20'h0, ad});
      apb(1'b1, `OFF_MDATA, {24'h0, v});
      apb(1'b1, `OFF_WREG, {24'h0, ~v});
      apb(1'b1, `OFF_STATUS, {31'h0, c});
      apb(1'b1, `OFF_INSTR, {16'h0, opc, d, a, f});
      wait_idle(n);
      chk("busy cycles", 32'h4, 32'(n));
      chk("wreg", {24'h0, d ? ~v : x[7:0]}, {24'h0, wreg_out});
      chk("flags", {29'h0, x[7], x[7:0] == 8'h00, x[8]}, {29'h0, flags_out});
      apb(1'b1, `OFF_MADDR, {20'h0, ad});
      apb(1'b0, `OFF_MDATA, 32'h0);
      chk("file byte", {24'h0, d ? x[7:0] : v}, rd);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_total = 0;
      comparisons = 0;
      void'($urandom(5));
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk("reset wreg", 32'h0, {24'h0, wreg_out});
      chk("reset flags", 32'h0, {29'h0, flags_out});
      for (int i = 0; i < 3; i++) begin
         run_op(ops[i], 1'b0, 1'b0, 4'h3, 8'h00, 8'h00, 1'b1);
         run_op(ops[i], 1'b1, 1'b1, 4'h5, 8'hff, 8'h81, 1'b0);
         run_op(ops[i], 1'b0, 1'b0, 4'h2, 8'h90, 8'h01, 1'b1);
         run_op(ops[i], 1'b1, 1'b0, 4'h9, 8'h7f, 8'hab, 1'b1);
      end
      for (int i = 0; i < 40; i++) begin
         r = $urandom();
         run_op(ops[r[1:0] % 2'h3], r[2], r[3], r[7:4], r[15:8], r[23:16], r[24]);
      end
      // opcode for rotate left via carry is not decoded
      apb(1'b1, `OFF_INSTR, 32'h0000_3400);
      wait_idle(cnt);
      chk("bad busy", 32'h1, 32'(cnt));
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("bad flag", 32'h1, {31'h0, rd[9]});
      // write while busy is refused and ignored
      apb(1'b1, `OFF_WREG, 32'h5a);
      apb(1'b1, `OFF_INSTR, {16'h0, `OPC_RR_PLAIN, 2'b10, 8'h10});
      apb(1'b1, `OFF_WREG, 32'ha5);
      chk("busy write err", 32'h1, {31'h0, er});
      wait_idle(cnt);
      chk("wreg kept", 32'h5a, {24'h0, wreg_out});
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      end_sim();
   end

endmodule
`default_nettype wire
